// ===== pclc_port_current_limit_control.sv
// Operation
// R1: Eight hardware current limit levels, chosen by the strap.
// R2: Strap sampled once after power-up, latched, never resampled.
// R3: Host may reprogram limit; never above the strapped hardware limit.
// R4: Sixteen strap codes; upper eight make enables active low; limits repeat.
// R5: Over-limit current is clamped within the short-circuit response time.
// R6: Over-limit persisting after clamping flags error and enters Error state.
// R7: Soft start on enable edge, or attach in Detect with enable held.
// R8: Soft start restricts supply-to-bus current while active.
// R9: Attach with enable on and over-limit: respond in response time, continue.
// R10: Trip or constant-current mode applies whenever the switch is closed; trip and short error act only in Active, not in soft start.
// R11: In Detect the bus current is capped by the bypass path.
// R12: In trip mode the switch opens when current exceeds the limit.
// R13: After a trip, enter Error and assert that port's alert.
// R14: After a trip, fault handling decides recovery.
// R15: Exactly one current limit is active per port at a time.
// R16: Alert outputs are active-low open-drain, asserted on port error.
// R17: In bus mode, ignore-pins bit drops the pins, else pins and bits combine.
// R18: Programmed limit above the hardware limit is clamped to it.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module pclc_port_current_limit_control
   import pclc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [STRAP_W-1:0] strap_config_pin,
   input wire logic port1_enable_pin,
   input wire logic port2_enable_pin,
   input wire pclc_sense_t sense1,
   input wire pclc_sense_t sense2,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [DATA_W-1:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [DATA_W-1:0] read_data,
   output pclc_drive_t drive1,
   output pclc_drive_t drive2,
   output logic alert1_n_out,
   output logic alert1_n_oe,
   output logic alert2_n_out,
   output logic alert2_n_oe,
   output logic interrupt
);

   typedef struct packed {
      pclc_strap_t strap;
      logic [DATA_W-1:0] config_reg;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      pclc_port_t [1:0] port;
      logic [DATA_W-1:0] read_data;
   } pclc_state_t;

   pclc_state_t state;
   pclc_state_t next_state;

   function automatic logic [LIMIT_W-1:0] clamp_limit(input logic [LIMIT_W-1:0] request,
                                                      input logic [LIMIT_W-1:0] hw);
      clamp_limit = (request > hw) ? hw : request; // [R3] [R18]
   endfunction

   // Effective enable from pin polarity, config bit and ignore bit
   function automatic logic port_enabled(input logic pin, input logic cfg_bit, input pclc_strap_t s,
                                         input logic ignore);
      logic pin_on;
      pin_on = pin ^ s.enable_active_low; // [R4]
      if (s.smbus_mode && ignore) begin
         port_enabled = cfg_bit; // [R17]
      end else if (s.smbus_mode) begin
         port_enabled = cfg_bit & pin_on; // [R17]
      end else begin
         port_enabled = pin_on;
      end
   endfunction

   logic [1:0] enable;
   pclc_sense_t [1:0] sense;

   assign sense[0] = sense1;
   assign sense[1] = sense2;
   assign enable[0] = port_enabled(port1_enable_pin, state.config_reg[CFG_EN1_BIT], state.strap,
                                   state.config_reg[CFG_IGNORE_BIT]);
   assign enable[1] = port_enabled(port2_enable_pin, state.config_reg[CFG_EN2_BIT], state.strap,
                                   state.config_reg[CFG_IGNORE_BIT]);

   always_comb begin
      logic [ST_W-1:0] events;
      logic [ST_W-1:0] clear;
      logic [DATA_W-1:0] rd;
      next_state = state;
      events = '0;
      clear = '0;
      rd = '0;

      // Strap caught once, at the first edge after reset release
      if (!state.strap.latched) begin // [R2]
         next_state.strap.strap = strap_config_pin;
         next_state.strap.hw_limit = strap_config_pin[LIMIT_W-1:0]; // [R1] [R4]
         next_state.strap.enable_active_low = strap_config_pin[STRAP_POL_BIT]; // [R4]
         next_state.strap.smbus_mode = 1'b1;
         next_state.strap.latched = 1'b1;
         for (int i = 0; i < 2; i++) begin
            next_state.port[i].limit = strap_config_pin[LIMIT_W-1:0];
         end
      end

      if (write_strobe) begin
         case (address)
            REG_CONFIG: next_state.config_reg = write_data & CONFIG_MASK;
            REG_LIMIT1: next_state.port[0].limit = clamp_limit(write_data[LIMIT_W-1:0],
                                                               state.strap.hw_limit); // [R18]
            REG_LIMIT2: next_state.port[1].limit = clamp_limit(write_data[LIMIT_W-1:0],
                                                               state.strap.hw_limit); // [R18]
            REG_STATUS: clear = write_data[ST_W-1:0];
            REG_MASK: next_state.mask = write_data[ST_W-1:0];
            default: ;
         endcase
      end

      for (int i = 0; i < 2; i++) begin
         logic recover;
         recover = write_strobe && address == REG_CONFIG && write_data[CFG_CLR1_BIT + i];
         next_state.port[i].en_prev = enable[i];
         case (state.port[i].state)
            PCLC_DETECT: begin
               next_state.port[i].count = '0;
               if (state.strap.latched && enable[i] && (!state.port[i].en_prev || sense[i].attach)) begin
                  next_state.port[i].state = PCLC_SOFT; // [R7]
                  if (sense[i].attach) begin
                     events[ST_SOFT1 + i] = 1'b1;
                  end
               end
            end
            PCLC_SOFT: begin
               if (!enable[i]) begin
                  next_state.port[i].state = PCLC_DETECT;
               end else if (state.port[i].count == CNT_W'(BUS_RISE_CYCLES - 1)) begin
                  next_state.port[i].state = PCLC_ACTIVE; // [R7]
                  next_state.port[i].count = '0;
               end else begin
                  next_state.port[i].count = state.port[i].count + 1'b1;
               end
            end
            PCLC_ACTIVE: begin
               if (!enable[i]) begin
                  next_state.port[i].state = PCLC_DETECT;
                  next_state.port[i].count = '0;
               end else if (sense[i].over_limit && !state.config_reg[CFG_CC1_BIT + i]) begin
                  next_state.port[i].state = PCLC_ERROR; // [R12] [R13]
                  events[ST_TRIP1 + i] = 1'b1;
               end else if (sense[i].over_limit) begin
                  // Clamp holds; error if still over after the response time
                  if (state.port[i].count == CNT_W'(SHORT_LIMIT_CYCLES)) begin
                     next_state.port[i].state = PCLC_ERROR; // [R6]
                     events[ST_SHORT1 + i] = 1'b1;
                     next_state.port[i].count = '0;
                  end else begin
                     next_state.port[i].count = state.port[i].count + 1'b1;
                  end
               end else begin
                  next_state.port[i].count = '0; // [R9]
               end
            end
            PCLC_ERROR: begin
               next_state.port[i].count = '0;
               if (recover) begin
                  next_state.port[i].state = PCLC_DETECT; // [R14]
               end
            end
            default: next_state.port[i].state = PCLC_DETECT;
         endcase
      end

      next_state.status = (state.status & ~clear) | events;

      if (read_strobe) begin
         case (address)
            REG_CONFIG: rd = state.config_reg;
            REG_LIMIT1: rd = DATA_W'(state.port[0].limit);
            REG_LIMIT2: rd = DATA_W'(state.port[1].limit);
            REG_STATUS: rd = DATA_W'(state.status);
            REG_MASK: rd = DATA_W'(state.mask);
            REG_STRAP: rd = DATA_W'({state.strap.hw_limit, state.strap.enable_active_low});
            REG_STATE: rd = DATA_W'({state.port[1].state, state.port[0].state});
            default: rd = '0;
         endcase
      end
      next_state.read_data = rd;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= '{strap: '0, config_reg: CONFIG_RESET, status: '0, mask: MASK_RESET,
                    port: '0, read_data: '0};
      end else begin
         state <= next_state;
      end
   end

   function automatic pclc_drive_t make_drive(input pclc_port_t p, input logic cc, input logic over);
      pclc_drive_t d;
      d.switch_on = p.state == PCLC_SOFT || p.state == PCLC_ACTIVE; // [R10]
      d.bypass_on = p.state == PCLC_DETECT; // [R11]
      d.soft_start = p.state == PCLC_SOFT; // [R8]
      d.current_clamp = d.switch_on && over; // [R5]
      d.cc_mode = cc; // [R10]
      d.current_limit_level = p.limit; // [R15]
      make_drive = d;
   endfunction

   assign drive1 = make_drive(state.port[0], state.config_reg[CFG_CC1_BIT], sense1.over_limit);
   assign drive2 = make_drive(state.port[1], state.config_reg[CFG_CC2_BIT], sense2.over_limit);
   assign read_data = state.read_data;
   assign alert1_n_out = 1'b0;
   assign alert2_n_out = 1'b0;
   assign alert1_n_oe = state.port[0].state == PCLC_ERROR; // [R13] [R16]
   assign alert2_n_oe = state.port[1].state == PCLC_ERROR; // [R16]
   assign interrupt = |(state.status & state.mask);

endmodule // pclc_port_current_limit_control

// ===== pclc_pkg.sv
package pclc_pkg;
   // Strap decode: 16 codes, 8 limit levels, upper half selects active-low enables
   localparam int STRAP_W = 4;
   localparam int LIMIT_W = 3;
   localparam int STRAP_POL_BIT = 3;
   localparam logic [LIMIT_W-1:0] LIMIT_MIN = 3'h0;

   // Register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
   localparam logic [ADDR_W-1:0] REG_LIMIT1 = 4'h1;
   localparam logic [ADDR_W-1:0] REG_LIMIT2 = 4'h2;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
   localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STRAP = 4'h5;
   localparam logic [ADDR_W-1:0] REG_STATE = 4'h6;

   // Config fields
   localparam int CFG_EN1_BIT = 0;
   localparam int CFG_EN2_BIT = 1;
   localparam int CFG_IGNORE_BIT = 2;
   localparam int CFG_CC1_BIT = 3;
   localparam int CFG_CC2_BIT = 4;
   localparam int CFG_CLR1_BIT = 5;
   localparam int CFG_CLR2_BIT = 6;
   localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h03;
   localparam logic [DATA_W-1:0] CONFIG_MASK = 8'h1f;

   // Status bits: per port trip, short error, attach soft start
   localparam int ST_TRIP1 = 0;
   localparam int ST_TRIP2 = 1;
   localparam int ST_SHORT1 = 2;
   localparam int ST_SHORT2 = 3;
   localparam int ST_SOFT1 = 4;
   localparam int ST_SOFT2 = 5;
   localparam int ST_W = 6;
   localparam logic [ST_W-1:0] MASK_RESET = 6'h3f;

   // Timing at 250 MHz
   localparam int CLOCK_MHZ = 250;
   localparam int SHORT_LIMIT_RESPONSE_NS = 100;
   localparam int BUS_RISE_TIME_NS = 4000;
   localparam int SHORT_LIMIT_CYCLES = (SHORT_LIMIT_RESPONSE_NS * CLOCK_MHZ) / 1000;
   localparam int BUS_RISE_CYCLES = (BUS_RISE_TIME_NS * CLOCK_MHZ) / 1000;
   localparam int CNT_W = 20;

   typedef enum logic [2:0] {
      PCLC_DETECT = 3'b000,
      PCLC_SOFT = 3'b001,
      PCLC_ACTIVE = 3'b011,
      PCLC_ERROR = 3'b010
   } pclc_port_state_t;

   typedef struct packed {
      logic [STRAP_W-1:0] strap;
      logic [LIMIT_W-1:0] hw_limit;
      logic enable_active_low;
      logic smbus_mode;
      logic latched;
   } pclc_strap_t;

   typedef struct packed {
      logic over_limit;
      logic attach;
   } pclc_sense_t;

   typedef struct packed {
      logic switch_on;
      logic bypass_on;
      logic soft_start;
      logic current_clamp;
      logic cc_mode;
      logic [LIMIT_W-1:0] current_limit_level;
   } pclc_drive_t;

   typedef struct packed {
      pclc_port_state_t state;
      logic en_prev;
      logic [CNT_W-1:0] count;
      logic [LIMIT_W-1:0] limit;
   } pclc_port_t;
endpackage

// ===== pclc_port_current_limit_control_asserts.sv
`timescale 1ns/1ps
module pclc_checker
   import pclc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [STRAP_W-1:0] strap_config_pin,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [DATA_W-1:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [DATA_W-1:0] read_data,
   input wire pclc_sense_t sense1,
   input wire pclc_drive_t drive1,
   input wire logic alert1_n_out,
   input wire logic alert1_n_oe
);
   logic seen;
   logic [LIMIT_W-1:0] hw_q;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Mirror of the one-time strap capture
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         seen <= 1'b0;
         hw_q <= '0;
      end else if (!seen) begin
         seen <= 1'b1;
         hw_q <= strap_config_pin[LIMIT_W-1:0];
      end
   end
   chk_limit_cap: assert property (seen |-> drive1.current_limit_level <= hw_q)
      else $error("limit above strap");
   chk_clamp_now: assert property (sense1.over_limit && drive1.switch_on |-> drive1.current_clamp)
      else $error("no clamp");
   chk_trip_opens: assert property (drive1.switch_on && !drive1.soft_start && !drive1.cc_mode
      && sense1.over_limit |=> !drive1.switch_on && alert1_n_oe) else $error("no trip");
   chk_alert_cause: assert property ($rose(alert1_n_oe) |-> $past(drive1.switch_on)
      && $past(sense1.over_limit)) else $error("alert without fault");
   chk_error_hold: assert property (alert1_n_oe && !(write_strobe && address == REG_CONFIG
      && write_data[CFG_CLR1_BIT]) |=> alert1_n_oe && !drive1.switch_on) else $error("error left");
   chk_alert_low: assert property (alert1_n_out == 1'b0)
      else $error("alert drives high");
   chk_path_excl: assert property (!(drive1.switch_on && drive1.bypass_on))
      else $error("both paths on");
   chk_soft_power: assert property (drive1.soft_start |-> drive1.switch_on && !drive1.bypass_on)
      else $error("soft start off switch");
   chk_read_idle: assert property (!read_strobe |=> read_data == 8'h00)
      else $error("read data stands");
endmodule // pclc_checker
bind pclc_port_current_limit_control pclc_checker i_chk (.clock(clock), .reset(reset),
   .strap_config_pin(strap_config_pin), .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .sense1(sense1),
   .drive1(drive1), .alert1_n_out(alert1_n_out), .alert1_n_oe(alert1_n_oe));

// ===== pclc_load_model.sv
`timescale 1ns/1ps
module pclc_load_model
   import pclc_pkg::*;
(
   input wire pclc_drive_t drive,
   input wire logic draw_high,
   input wire logic attach_req,
   output pclc_sense_t sense
);
   // Heavy draw only reads as over-limit while the switch conducts
   assign sense.over_limit = draw_high & drive.switch_on;
   assign sense.attach = attach_req & drive.bypass_on;
endmodule // pclc_load_model

// ===== pclc_port_current_limit_control_tb.sv
`timescale 1ns/1ps
module pclc_port_current_limit_control_tb;
   import pclc_pkg::*;
   typedef struct packed {logic wr; logic [3:0] a; logic [7:0] d; logic [7:0] e;} pclc_row_t;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [3:0] strap = 4'hd;
   logic pin1 = 1'b1, pin2 = 1'b1, ws = 1'b0, rs = 1'b0, draw1 = 1'b0, att = 1'b0;
   logic [3:0] address = 4'h0;
   logic [7:0] wdata = 8'h00, rdata;
   pclc_sense_t sense1, sense2;
   pclc_drive_t drive1, drive2;
   logic a1o, a1e, a2o, a2e, irq;
   int error_cnt = 0;
   int checks = 0;
   pclc_row_t rows[13] = '{'{1'b0, REG_CONFIG, 8'h00, 8'h03}, '{1'b0, REG_MASK, 8'h00, 8'h3f},
      '{1'b0, REG_LIMIT1, 8'h00, 8'h05}, '{1'b0, REG_STRAP, 8'h00, 8'h0b}, '{1'b0, REG_STATE, 8'h00, 8'h00},
      '{1'b1, REG_LIMIT1, 8'h02, 8'h02}, '{1'b1, REG_LIMIT1, 8'h07, 8'h05}, '{1'b1, REG_LIMIT2, 8'h04, 8'h04},
      '{1'b1, REG_LIMIT2, 8'h06, 8'h05}, '{1'b1, REG_MASK, 8'h15, 8'h15}, '{1'b1, REG_CONFIG, 8'he0, 8'h00},
      '{1'b1, REG_STRAP, 8'h00, 8'h0b}, '{1'b1, 4'hf, 8'h5a, 8'h00}};
   pclc_port_current_limit_control i_dut (.clock(clock), .reset(reset), .strap_config_pin(strap),
      .port1_enable_pin(pin1), .port2_enable_pin(pin2), .sense1(sense1), .sense2(sense2), .address(address),
      .write_data(wdata), .write_strobe(ws), .read_strobe(rs), .read_data(rdata), .drive1(drive1),
      .drive2(drive2), .alert1_n_out(a1o), .alert1_n_oe(a1e), .alert2_n_out(a2o), .alert2_n_oe(a2e),
      .interrupt(irq));
   pclc_load_model i_load1 (.drive(drive1), .draw_high(draw1), .attach_req(att), .sense(sense1));
   pclc_load_model i_load2 (.drive(drive2), .draw_high(1'b0), .attach_req(att), .sense(sense2));
   always #2 clock = ~clock;
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      ws <= 1'b1;
      address <= a;
      wdata <= d;
      @(posedge clock);
      ws <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      rs <= 1'b1;
      address <= a;
      @(posedge clock);
      rs <= 1'b0;
      #1 chk("read_data", e, rdata);
   endtask
   task conclude;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      conclude();
   end
   // Soft start spans 1000 cycles; trip, short and recovery are driven by hand below
   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      @(posedge clock);
      strap <= 4'h0;
      rd(REG_STRAP, 8'h0b);
      chk("drive1", 8'h45, drive1);
      wr(REG_CONFIG, 8'h01);
      pin1 <= 1'b0;
      repeat (3) @(posedge clock);
      #1 chk("drive1", 8'ha5, drive1);
      rd(REG_STATE, 8'h01);
      @(posedge clock);
      draw1 <= 1'b1;
      #1 chk("drive1", 8'hb5, drive1);
      repeat (30) @(posedge clock);
      rd(REG_STATE, 8'h01);
      chk("alert1", 8'h00, {6'h0, a1o, a1e});
      @(posedge clock);
      draw1 <= 1'b0;
      wr(REG_CONFIG, 8'h06);
      repeat (3) @(posedge clock);
      rd(REG_STATE, 8'h08);
      wr(REG_LIMIT2, 8'h03);
      #1 chk("drive2", 8'ha3, drive2);
      chk("interrupt", 8'h00, {7'h0, irq});
      // Trip mode on port 1: reach Active, then overdraw
      wr(REG_CONFIG, 8'h05);
      repeat (1010) @(posedge clock);
      rd(REG_STATE, 8'h03);
      chk("drive1", 8'h85, drive1);
      @(posedge clock);
      draw1 <= 1'b1;
      #1 chk("drive1", 8'h95, drive1);
      @(posedge clock);
      #1 chk("alert1", 8'h01, {6'h0, a1o, a1e});
      chk("drive1", 8'h05, drive1);
      rd(REG_STATUS, 8'h01);
      chk("interrupt", 8'h01, {7'h0, irq});
      wr(REG_STATUS, 8'h01);
      #1 chk("interrupt", 8'h00, {7'h0, irq});
      @(posedge clock);
      draw1 <= 1'b0;
      wr(REG_CONFIG, 8'h25);
      rd(REG_STATE, 8'h00);
      chk("alert1", 8'h00, {6'h0, a1o, a1e});
      // Attach in Detect with enable already on starts soft start
      @(posedge clock);
      att <= 1'b1;
      @(posedge clock);
      att <= 1'b0;
      rd(REG_STATE, 8'h01);
      rd(REG_STATUS, 8'h10);
      chk("interrupt", 8'h01, {7'h0, irq});
      // Constant-current mode: error only after the response time
      repeat (1010) @(posedge clock);
      wr(REG_CONFIG, 8'h0d);
      @(posedge clock);
      draw1 <= 1'b1;
      repeat (25) @(posedge clock);
      #1 chk("alert1", 8'h00, {6'h0, a1o, a1e});
      @(posedge clock);
      #1 chk("alert1", 8'h01, {6'h0, a1o, a1e});
      rd(REG_STATUS, 8'h14);
      conclude();
   end
endmodule // pclc_port_current_limit_control_tb
